// ==== aerue_pkg.sv ====
// Shared constants and types for the uncorrectable error register bank.
// Assumes a 32-bit APB slave with byte addresses inside one function's
// configuration space.
package aerue_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] AERUE_OFS_HEADER   = 12'h100;
  localparam logic [11:0] AERUE_OFS_FLAGS    = 12'h104;
  localparam logic [11:0] AERUE_OFS_SUPPRESS = 12'h108;

  // ****************************************************************
  // Capability header fields
  // ****************************************************************
  localparam int          AERUE_HDR_ID_LSB   = 0;
  localparam int          AERUE_HDR_VER_LSB  = 16;
  localparam int          AERUE_HDR_NEXT_LSB = 20;
  localparam logic [15:0] AERUE_HDR_ID       = 16'h0001;
  localparam logic [3:0]  AERUE_HDR_VER      = 4'h1;
  localparam logic [11:0] AERUE_HDR_NEXT     = 12'h140;

  // ****************************************************************
  // Error bit positions and reset values
  // ****************************************************************
  localparam int AERUE_BIT_TRAIN    = 0;
  localparam int AERUE_BIT_DLPROT   = 4;
  localparam int AERUE_BIT_POISON   = 12;
  localparam int AERUE_BIT_FCPROT   = 13;
  localparam int AERUE_BIT_CPLTO    = 14;
  localparam int AERUE_BIT_CPLABT   = 15;
  localparam int AERUE_BIT_UNEXCPL  = 16;
  localparam int AERUE_BIT_RXOVF    = 17;
  localparam int AERUE_BIT_MALF     = 18;
  localparam int AERUE_BIT_E2ECRC   = 19;
  localparam int AERUE_BIT_UNSUPREQ = 20;
  localparam int AERUE_BIT_ACSVIOL  = 21;

  localparam logic [31:0] AERUE_IMPL_MASK     = 32'h003F_F011;
  localparam logic [31:0] AERUE_FLAGS_RESET   = 32'h0000_0000;
  localparam logic [31:0] AERUE_SUPPRESS_RESET = 32'h0000_0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  // One bit per uncorrectable error class
  typedef struct packed {
    logic acs_violation;
    logic unsupported_req;
    logic e2e_crc;
    logic malformed;
    logic rx_overflow;
    logic unexpected_cpl;
    logic completer_abort;
    logic cpl_timeout;
    logic fc_protocol;
    logic poisoned;
    logic dl_protocol;
    logic training;
  } aerue_err_t;

endpackage : aerue_pkg

// ==== aerue_regs.sv ====
// Uncorrectable error reporting registers of one switch port: capability
// header, sticky error flags and suppress mask, reached over APB.
// Assumes event strobes come from logic on pclk, one cycle per event.
//
// How it works
// - Header low sixteen bits always read 0001h as capability identifier.
// - Header bits 19:16 always read version value 1h.
// - Header bits 31:20 read-only next pointer, fixed at 140h.
// - Bit 0 sets on training error; all flags reset zero, write-one clears.
// - Bit 4 sets on data link layer protocol error.
// - Bit 12 sets on poisoned packet received or generated.
// - Bit 13 sets on flow control protocol error.
// - Bit 14 sets on completion timeout.
// - Bit 15 sets on completer abort.
// - Bit 16 sets on completion matching no outstanding request.
// - Bit 17 sets on receive buffer overflow.
// - Bit 18 sets on malformed packet received.
// - Bit 19 sets on end-to-end CRC error.
// - Bit 20 sets on unsupported request.
// - Bit 21 sets on access control services violation.
// - Suppress bit blocks logging and error message; read-write, resets zero.
// - Suppress bits sit at the same positions as the flag bits.
`timescale 1ns/1ns
module aerue_regs (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Error events from the port core, one-cycle strobes
  input  aerue_pkg::aerue_err_t  err_event,
  input  wire logic              poison_generated,
  // Reporting towards header log and message generation
  output aerue_pkg::aerue_err_t  err_report,
  output aerue_pkg::aerue_err_t  err_flags,
  output logic                   irq
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Spread the packed error classes onto their register positions
  function automatic logic [31:0] to_vec(input aerue_pkg::aerue_err_t e);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[aerue_pkg::AERUE_BIT_TRAIN]    = e.training;
    v[aerue_pkg::AERUE_BIT_DLPROT]   = e.dl_protocol;
    v[aerue_pkg::AERUE_BIT_POISON]   = e.poisoned;
    v[aerue_pkg::AERUE_BIT_FCPROT]   = e.fc_protocol;
    v[aerue_pkg::AERUE_BIT_CPLTO]    = e.cpl_timeout;
    v[aerue_pkg::AERUE_BIT_CPLABT]   = e.completer_abort;
    v[aerue_pkg::AERUE_BIT_UNEXCPL]  = e.unexpected_cpl;
    v[aerue_pkg::AERUE_BIT_RXOVF]    = e.rx_overflow;
    v[aerue_pkg::AERUE_BIT_MALF]     = e.malformed;
    v[aerue_pkg::AERUE_BIT_E2ECRC]   = e.e2e_crc;
    v[aerue_pkg::AERUE_BIT_UNSUPREQ] = e.unsupported_req;
    v[aerue_pkg::AERUE_BIT_ACSVIOL]  = e.acs_violation;
    return v;
  endfunction : to_vec

  function automatic aerue_pkg::aerue_err_t to_err(input logic [31:0] v);
    aerue_pkg::aerue_err_t e;
    e.training        = v[aerue_pkg::AERUE_BIT_TRAIN];
    e.dl_protocol     = v[aerue_pkg::AERUE_BIT_DLPROT];
    e.poisoned        = v[aerue_pkg::AERUE_BIT_POISON];
    e.fc_protocol     = v[aerue_pkg::AERUE_BIT_FCPROT];
    e.cpl_timeout     = v[aerue_pkg::AERUE_BIT_CPLTO];
    e.completer_abort = v[aerue_pkg::AERUE_BIT_CPLABT];
    e.unexpected_cpl  = v[aerue_pkg::AERUE_BIT_UNEXCPL];
    e.rx_overflow     = v[aerue_pkg::AERUE_BIT_RXOVF];
    e.malformed       = v[aerue_pkg::AERUE_BIT_MALF];
    e.e2e_crc         = v[aerue_pkg::AERUE_BIT_E2ECRC];
    e.unsupported_req = v[aerue_pkg::AERUE_BIT_UNSUPREQ];
    e.acs_violation   = v[aerue_pkg::AERUE_BIT_ACSVIOL];
    return e;
  endfunction : to_err

  // Byte enables widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction : strb_mask

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic        access;
  logic        wr_en;
  logic        hit_hdr;
  logic        hit_flags;
  logic        hit_supp;
  logic        unmapped;
  logic [31:0] wmask;
  logic [31:0] hdr_value;
  logic [31:0] evt_vec;

  // Zero wait states: every access completes in its first access cycle
  assign pready    = 1'b1;
  assign access    = psel & penable;
  assign wr_en     = access & pwrite;
  assign hit_hdr   = (paddr == aerue_pkg::AERUE_OFS_HEADER);
  assign hit_flags = (paddr == aerue_pkg::AERUE_OFS_FLAGS);
  assign hit_supp  = (paddr == aerue_pkg::AERUE_OFS_SUPPRESS);
  assign unmapped  = ~(hit_hdr | hit_flags | hit_supp);
  assign wmask     = strb_mask(pstrb) & pwdata & aerue_pkg::AERUE_IMPL_MASK;

  // Header is hard wired; writes to it are dropped without error
  assign hdr_value = {aerue_pkg::AERUE_HDR_NEXT,
                      aerue_pkg::AERUE_HDR_VER,
                      aerue_pkg::AERUE_HDR_ID};

  // Poisoned packet counts whether seen inbound or made here
  always_comb begin
    aerue_pkg::aerue_err_t ev;
    ev          = err_event;
    ev.poisoned = err_event.poisoned | poison_generated;
    evt_vec     = to_vec(ev);
  end

  // ****************************************************************
  // Error flags
  // ****************************************************************
  logic [31:0] flags_q;
  logic [31:0] flags_d;
  logic [31:0] supp_q;

  // Set beats clear so a strobe in the clearing cycle is never lost
  always_comb begin
    flags_d = flags_q;
    if (wr_en && hit_flags) begin
      flags_d = flags_q & ~wmask;
    end
    // Suppress plays no part here: masked events still land
    flags_d = (flags_d | evt_vec) & aerue_pkg::AERUE_IMPL_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= aerue_pkg::AERUE_FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ****************************************************************
  // Suppress mask
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supp_q <= aerue_pkg::AERUE_SUPPRESS_RESET;
    end else if (wr_en && hit_supp) begin
      // Only lanes enabled by pstrb change; reserved bits stay zero
      supp_q <= (supp_q & ~(strb_mask(pstrb) & aerue_pkg::AERUE_IMPL_MASK))
              | wmask;
    end
  end

  // ****************************************************************
  // Reporting
  // ****************************************************************
  // Registered so log and message logic see clean one-cycle pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_report <= '0;
    end else begin
      err_report <= to_err(evt_vec & ~supp_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_d & ~supp_q);
    end
  end

  assign err_flags = to_err(flags_q);

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      // Captured in setup so data is stable through the access cycle
      pslverr <= unmapped;
      if (pwrite || unmapped) begin
        prdata <= 32'h0000_0000;
      end else if (hit_hdr) begin
        prdata <= hdr_value;
      end else if (hit_flags) begin
        prdata <= flags_q & aerue_pkg::AERUE_IMPL_MASK;
      end else begin
        prdata <= supp_q & aerue_pkg::AERUE_IMPL_MASK;
      end
    end else if (!psel) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

endmodule : aerue_regs

// ==== aerue_chk.sv ====
// Checker for the uncorrectable error register bank.
// Assumes it is bound onto aerue_regs; one clock domain.
`timescale 1ns/1ns
module aerue_chk (
  // Clock and reset
  input wire logic             pclk,
  input wire logic             presetn,
  // APB
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [3:0]       pstrb,
  input wire logic             pready,
  input wire logic [31:0]      prdata,
  input wire logic             pslverr,
  // Events and reporting
  input aerue_pkg::aerue_err_t err_event,
  input wire logic             poison_generated,
  input aerue_pkg::aerue_err_t err_report,
  input aerue_pkg::aerue_err_t err_flags,
  input wire logic             irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [11:0] ev;
  logic [11:0] fl;
  logic        rd;
  // Generated poison folds into the received poison class
  assign ev = err_event | {9'h0, poison_generated, 2'h0};
  assign fl = err_flags;
  assign rd = psel && !penable && !pwrite;
  property p_hdr; rd && paddr == 12'h100 |=> prdata == 32'h1401_0001;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header read");
  property p_set; ev != 12'h0 |=> ($past(ev) & ~fl) == 12'h0; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_pois; poison_generated |=> err_flags.poisoned; endproperty
  a_pois: assert property (p_pois) else $error("poison flag");
  property p_clr; !(psel && penable && pwrite && paddr == 12'h104)
    |=> ($past(fl) & ~fl) == 12'h0; endproperty
  a_clr: assert property (p_clr) else $error("flag lost");
  property p_rep; (err_report & ~$past(ev)) == 12'h0; endproperty
  a_rep: assert property (p_rep) else $error("stray report");
  property p_irq; irq |-> fl != 12'h0; endproperty
  a_irq: assert property (p_irq) else $error("stray irq");
  property p_rsv; rd && (paddr == 12'h104 || paddr == 12'h108)
    |=> (prdata & ~aerue_pkg::AERUE_IMPL_MASK) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_slv; psel && !penable && paddr > 12'h108
    |=> pslverr && prdata == 32'h0; endproperty
  a_slv: assert property (p_slv) else $error("unmapped");
  c_ev: cover property (ev != 12'h0);
  c_clr: cover property (psel && penable && pwrite && paddr == 12'h104);
  c_irq: cover property (irq ##1 !irq);
endmodule : aerue_chk

bind aerue_regs aerue_chk u_aerue_chk (.*);

// ==== aerue_apb_host.sv ====
// APB requester standing in for configuration software.
// Assumes the testbench calls xfer one transfer at a time.
`timescale 1ns/1ns
module aerue_apb_host (
  // Clock
  input  wire logic        pclk,
  // APB requester
  output logic             psel = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite = 1'b0,
  output logic [11:0]      paddr = 12'h0,
  output logic [31:0]      pwdata = 32'h0,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle bus shows no stale request
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : aerue_apb_host

// ==== testbench.sv ====
// Self-checking bench for the uncorrectable error register bank.
// Assumes the APB requester model and the bound checker.
`timescale 1ns/1ns
module testbench;
  `define CHK(g, x) begin compares++; if ((g) !== (x)) begin fails++; \
    $display("BAD %0t got %h exp %h", $time, g, x); end end
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  poison_generated = 1'b0;
  logic [3:0]            pstrb = 4'hF;
  logic                  psel, penable, pwrite, pready, pslverr, irq, perr, p;
  logic [11:0]           paddr, m, e, w;
  logic [31:0]           pwdata, prdata, rdat;
  aerue_pkg::aerue_err_t err_event = '0;
  aerue_pkg::aerue_err_t err_report, err_flags;
  int                    fails = 0, compares = 0, seed = 32'hfe52, k;

  aerue_regs u_aerue_regs (.*);
  aerue_apb_host u_aerue_apb_host (.*);
  always #5 pclk = ~pclk;

  function automatic logic [31:0] pos(logic [11:0] v);
    return {10'h0, v[11:2], 7'h0, v[1], 3'h0, v[0]};
  endfunction : pos
  task rw(input logic wr, input logic [11:0] a, input logic [31:0] d);
    u_aerue_apb_host.xfer(wr, a, d, rdat, perr);
  endtask : rw
  task end_of_test;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  // Whole run is under a thousand cycles
  initial begin
    #100000;
    fails++;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rw(1'b0, 12'h100, 32'h0);
    `CHK(rdat[15:0], 16'h0001)
    `CHK(rdat[19:16], 4'h1)
    rw(1'b1, 12'h100, '1);
    rw(1'b0, 12'h100, 32'h0);
    `CHK(rdat, 32'h1401_0001)
    `CHK(rdat[31:20], 12'h140)
    rw(1'b0, 12'h104, 32'h0);
    `CHK(rdat, 32'h0)
    rw(1'b0, 12'h108, 32'h0);
    `CHK(rdat, 32'h0)
    rw(1'b1, 12'h108, '1);
    rw(1'b0, 12'h108, 32'h0);
    `CHK(rdat, aerue_pkg::AERUE_IMPL_MASK)
    // Only the enabled byte lane may change
    pstrb <= 4'h4;
    rw(1'b1, 12'h108, 32'h0);
    pstrb <= 4'hF;
    rw(1'b0, 12'h108, 32'h0);
    `CHK(rdat, 32'h0000_F011)
    rw(1'b1, 12'h104, '1);
    rw(1'b0, 12'h104, 32'h0);
    `CHK(rdat, 32'h0)
    rw(1'b0, 12'h10C, 32'h0);
    `CHK({perr, rdat}, 33'h1_0000_0000)
    $display("test registers done");
    for (k = 0; k < 40; k++) begin
      e = k < 12 ? 12'h1 << k : 12'($random(seed));
      p = k > 11 ? 1'($random(seed)) : 1'b0;
      m = 12'($random(seed));
      rw(1'b1, 12'h108, pos(m));
      @(posedge pclk);
      err_event <= e;
      poison_generated <= p;
      e = e | {9'h0, p, 2'h0};
      @(posedge pclk);
      err_event <= '0;
      poison_generated <= 1'b0;
      #1;
      `CHK(err_report, e & ~m)
      `CHK(irq, |(e & ~m))
      `CHK(err_flags, e)
      rw(1'b0, 12'h104, 32'h0);
      `CHK(rdat, pos(e))
      w = 12'($random(seed));
      rw(1'b1, 12'h104, pos(w));
      rw(1'b0, 12'h104, 32'h0);
      `CHK(rdat, pos(e & ~w))
      rw(1'b1, 12'h104, '1);
    end
    $display("test events done");
    end_of_test;
  end
endmodule : testbench
